/* hsw_defines.svh */
// timing, address and field constants of the hot-swap sequencer
`ifndef HSW_DEFINES_SVH
`define HSW_DEFINES_SVH
`define HSW_CLK_MHZ        200
`define HSW_TICK_CYC       (`HSW_CLK_MHZ)
`define HSW_T_UVLO_US      37500
`define HSW_T_START_US     9000
`define HSW_T_POWER_GOOD_N_US     750
`define HSW_T_CLEAR_US     100
`define HSW_T_SLOW_MIN_US  100
`define HSW_T_SLOW_MAX_US  3000
`define HSW_T_GLITCH_US    20
`define HSW_T_FAST_NS      260
`define HSW_FAST_CYC       ((`HSW_T_FAST_NS * `HSW_CLK_MHZ) / 1000)
`define HSW_RETRY_PERIODS  64
`define HSW_ADDR_CTRL      12'h000
`define HSW_ADDR_START     12'h004
`define HSW_ADDR_STATUS    12'h008
`define HSW_ADDR_EVENT     12'h00C
`define HSW_CTRL_RETRY     0
`define HSW_CTRL_MONITOR   1
`define HSW_CTRL_RST       2'h0
`define HSW_EV_RST         4'h0
`endif

/* hsw_pkg.sv */
// types of the hot-swap sequencer
package hsw_pkg;
   typedef enum logic [2:0] {
      ST_LOCK  = 3'b000,
      ST_WAIT  = 3'b001,
      ST_START = 3'b010,
      ST_PGDLY = 3'b011,
      ST_RUN   = 3'b100,
      ST_FAULT = 3'b101,
      ST_RETRY = 3'b110
   } hsw_state_t;
   typedef struct packed {
      logic [1:0] sup;
      logic [1:0] on;
      logic [1:0] slow;
      logic [1:0] big;
      logic [1:0] fast;
      logic [1:0] win;
      logic [1:0] pg;
      logic       tim_float;
   } hsw_pins_t;
endpackage

/* hsw_cnt_if.sv */
// persistence counter carrier
`timescale 1ns/1ps
`default_nettype none
interface hsw_cnt_if;
   logic        tick;
   logic        level;
   logic [15:0] limit;
   logic        hit;
   modport drv (output tick, output level, output limit, input hit);
   modport cnt (input tick, input level, input limit, output hit);
endinterface
`default_nettype wire

/* hsw_persist.sv */
// flags a level that has held for limit microsecond ticks
`timescale 1ns/1ps
`default_nettype none
module hsw_persist (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // counter carrier
   hsw_cnt_if.cnt    cif
);
   logic [15:0] cnt_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 16'h0000;
      end else if (!cif.level) begin
         cnt_r <= 16'h0000;
      end else if (cif.tick && cnt_r != cif.limit) begin
         cnt_r <= cnt_r + 16'h0001;
      end
   end

   assign cif.hit = cif.level && (cnt_r == cif.limit);
endmodule // hsw_persist
`default_nettype wire

/* hsw_seq.sv */
// dual-channel hot-swap sequencing and fault state machine
// Functional notes
// - startup waits until a supply held above lockout for the lockout delay
// - startup also needs both enables high and no latch or retry wait
// - floating timer pin gives 9 ms startup, else programmed up to 65535 us
// - slow overcurrent comparator is ignored during startup
// - fast trip in startup only regulates the gate, never faults
// - power-good releases 0.75 ms after startup ends if fault-free
// - sustained slow trip faults, 3 ms small down to 100 us large overdrive
// - fast trip in normal operation faults within 260 ns
// - any overcurrent drops both power-goods and discharges both gates
// - window fault: protect shuts both, monitor drops only its power-good
// - monitor variant power-good returns once the window fault clears
// - latched fault clears only by enable low or supply cycle of 100 us
// - autoretry restarts after 64 startup periods
// - enable low during retry wait neither clears nor shortens it
// - supply cycle across lockout overrides retry, startup begins at once
// - both supplies below lockout restarts lockout delay then startup
// - power-good low in startup, enable low, channel off or fault
// - each channel enabled only while its enable input is high
// - window monitoring only after the startup period
// - window violations shorter than 20 us are ignored
`timescale 1ns/1ps
`default_nettype none
`include "hsw_defines.svh"
module hsw_seq import hsw_pkg::*; #(
   parameter logic [15:0] UVLO_US     = 16'(`HSW_T_UVLO_US),
   parameter logic [15:0] START_US    = 16'(`HSW_T_START_US),
   parameter logic [15:0] POWER_GOOD_N_US    = 16'(`HSW_T_POWER_GOOD_N_US),
   parameter logic [15:0] CLEAR_US    = 16'(`HSW_T_CLEAR_US),
   parameter logic [15:0] SLOW_MIN_US = 16'(`HSW_T_SLOW_MIN_US),
   parameter logic [15:0] SLOW_MAX_US = 16'(`HSW_T_SLOW_MAX_US)
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // supply and enable comparators
   input  wire logic        supply_in_ch1,
   input  wire logic        supply_in_ch2,
   input  wire logic        chan1_enable_in,
   input  wire logic        chan2_enable_in,
   input  wire logic        startup_time_set,
   // current and window comparators
   input  wire logic        slow_trip_ch1,
   input  wire logic        slow_trip_ch2,
   input  wire logic        slow_big_ch1,
   input  wire logic        slow_big_ch2,
   input  wire logic        fast_trip_ch1,
   input  wire logic        fast_trip_ch2,
   input  wire logic        output_window_ch1,
   input  wire logic        output_window_ch2,
   // gate control
   output logic             gate_drive_ch1,
   output logic             gate_drive_ch2,
   output logic             gate_limit_ch1,
   output logic             gate_limit_ch2,
   output logic             gate_discharge,
   // open-drain power-good pins
   input  wire logic        power_good_ch1_in,
   input  wire logic        power_good_ch2_in,
   output logic             power_good_ch1_out,
   output logic             power_good_ch1_oe,
   output logic             power_good_ch2_out,
   output logic             power_good_ch2_oe
);
   hsw_pins_t  pins;
   hsw_pins_t  s1_r;
   hsw_pins_t  s;
   hsw_state_t state_r;
   hsw_state_t state_nxt;
   logic [7:0]  div_r;
   logic        tick;
   logic [15:0] uv_cnt_r;
   logic        uv_done;
   logic        both_low;
   logic [15:0] lo_cnt_r [4];
   logic [3:0]  lvl;
   logic [3:0]  cyc_ev;
   logic        on_cyc;
   logic        sup_cyc;
   logic        all_on;
   logic [15:0] tmr_r;
   logic [15:0] lim;
   logic [15:0] start_len;
   logic        tdone;
   logic [5:0]  per_r;
   logic        norm;
   logic        gate_st;
   logic        flt;
   logic [1:0]  oc;
   logic [1:0]  win_hit;
   logic [1:0]  gate_r;
   logic [1:0]  lim_r;
   logic        dis_r;
   logic [1:0]  pg_rel_r;
   logic [1:0]  ctrl_r;
   logic [15:0] start_r;
   logic [3:0]  ev_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_nxt;
   logic        amap;
   logic        wr;

   // pin synchroniser
   assign pins = '{sup: {supply_in_ch2, supply_in_ch1},
                   on: {chan2_enable_in, chan1_enable_in},
                   slow: {slow_trip_ch2, slow_trip_ch1},
                   big: {slow_big_ch2, slow_big_ch1},
                   fast: {fast_trip_ch2, fast_trip_ch1},
                   win: {output_window_ch2, output_window_ch1},
                   pg: {power_good_ch2_in, power_good_ch1_in},
                   tim_float: startup_time_set};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s    <= '0;
      end else begin
         s1_r <= pins;
         s    <= s1_r;
      end
   end

   // microsecond time base
   assign tick = (div_r == 8'(`HSW_TICK_CYC - 1));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 8'h00;
      end else if (tick) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end

   // lockout delay
   assign both_low = ~|s.sup;
   assign uv_done  = (uv_cnt_r == UVLO_US);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         uv_cnt_r <= 16'h0000;
      end else if (both_low) begin
         uv_cnt_r <= 16'h0000;
      end else if (tick && !uv_done) begin
         uv_cnt_r <= uv_cnt_r + 16'h0001;
      end
   end

   // long-low then high detectors for enables and supplies
   assign lvl = {s.on, s.sup};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            lo_cnt_r[i] <= 16'h0000;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (lvl[i]) begin
               lo_cnt_r[i] <= 16'h0000;
            end else if (tick && lo_cnt_r[i] != CLEAR_US) begin
               lo_cnt_r[i] <= lo_cnt_r[i] + 16'h0001;
            end
         end
      end
   end

   for (genvar i = 0; i < 4; i++) begin : g_cyc
      assign cyc_ev[i] = lvl[i] && (lo_cnt_r[i] == CLEAR_US);
   end

   assign on_cyc  = |cyc_ev[3:2];
   assign sup_cyc = |cyc_ev[1:0];
   assign all_on  = &s.on;

   // overcurrent and window detection per channel
   assign norm = (state_r == ST_PGDLY) || (state_r == ST_RUN);

   for (genvar c = 0; c < 2; c++) begin : g_ch
      hsw_cnt_if slo ();
      hsw_cnt_if sbig ();
      hsw_cnt_if win ();
      assign slo.tick   = tick;
      assign slo.level  = norm && s.slow[c];
      assign slo.limit  = SLOW_MAX_US;
      assign sbig.tick  = tick;
      assign sbig.level = norm && s.big[c];
      assign sbig.limit = SLOW_MIN_US;
      assign win.tick   = tick;
      assign win.level  = norm && s.win[c];
      assign win.limit  = 16'(`HSW_T_GLITCH_US);
      hsw_persist u_slo (.pclk(pclk), .presetn(presetn), .cif(slo));
      hsw_persist u_big (.pclk(pclk), .presetn(presetn), .cif(sbig));
      hsw_persist u_win (.pclk(pclk), .presetn(presetn), .cif(win));
      assign oc[c] = slo.hit || sbig.hit || (norm && s.fast[c]);
      assign win_hit[c] = win.hit;
   end

   assign flt = (|oc) || (!ctrl_r[`HSW_CTRL_MONITOR] && (|win_hit));

   // period select and timer end
   assign start_len = !s.tim_float ?
                      ((start_r == 16'h0000) ? 16'h0001 : start_r) :
                      START_US;

   always_comb begin
      case (state_r)
         ST_PGDLY: lim = POWER_GOOD_N_US;
         default:  lim = start_len;
      endcase
   end

   assign tdone = tick && (tmr_r == lim - 16'h0001);

   // sequencing state machine
   always_comb begin
      state_nxt = state_r;
      if (both_low) begin
         state_nxt = ST_LOCK;
      end else begin
         case (state_r)
            ST_LOCK: begin
               if (uv_done) state_nxt = ST_WAIT;
            end
            ST_WAIT: begin
               if (all_on) state_nxt = ST_START;
            end
            ST_START: begin
               if (!all_on) state_nxt = ST_WAIT;
               else if (tdone) state_nxt = ST_PGDLY;
            end
            ST_PGDLY, ST_RUN: begin
               if (flt) begin
                  state_nxt = ctrl_r[`HSW_CTRL_RETRY] ? ST_RETRY : ST_FAULT;
               end else if (state_r == ST_PGDLY && tdone) begin
                  state_nxt = ST_RUN;
               end
            end
            ST_FAULT: begin
               if (on_cyc || sup_cyc) state_nxt = ST_WAIT;
            end
            ST_RETRY: begin
               if (sup_cyc) begin
                  state_nxt = (all_on && uv_done) ? ST_START : ST_WAIT;
               end else if (tdone &&
                            per_r == 6'(`HSW_RETRY_PERIODS - 1)) begin
                  state_nxt = ST_WAIT;
               end
            end
            default: state_nxt = ST_LOCK;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_LOCK;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tmr_r <= 16'h0000;
      end else if (state_nxt != state_r || tdone) begin
         tmr_r <= 16'h0000;
      end else if (tick) begin
         tmr_r <= tmr_r + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_r <= 6'h00;
      end else if (state_r != ST_RETRY) begin
         per_r <= 6'h00;
      end else if (tdone) begin
         per_r <= per_r + 6'h01;
      end
   end

   // gate and power-good outputs
   assign gate_st = (state_r == ST_START) || norm;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_r   <= 2'h0;
         lim_r    <= 2'h0;
         dis_r    <= 1'b0;
         pg_rel_r <= 2'h0;
      end else begin
         gate_r   <= {2{gate_st && !flt}} & s.on;
         lim_r    <= {2{state_r == ST_START}} & s.fast & s.on;
         dis_r    <= (state_r == ST_FAULT) || (state_r == ST_RETRY) ||
                     (norm && flt);
         pg_rel_r <= {2{state_r == ST_RUN && !flt}} & s.on &
                     ~win_hit;
      end
   end

   assign gate_drive_ch1     = gate_r[0];
   assign gate_drive_ch2     = gate_r[1];
   assign gate_limit_ch1     = lim_r[0];
   assign gate_limit_ch2     = lim_r[1];
   assign gate_discharge     = dis_r;
   assign power_good_ch1_out = 1'b0;
   assign power_good_ch2_out = 1'b0;
   assign power_good_ch1_oe  = !pg_rel_r[0];
   assign power_good_ch2_oe  = !pg_rel_r[1];

   // apb register file
   assign amap = (paddr == `HSW_ADDR_CTRL) || (paddr == `HSW_ADDR_START) ||
                 (paddr == `HSW_ADDR_STATUS) || (paddr == `HSW_ADDR_EVENT);
   assign wr      = psel && penable && pwrite && amap;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !amap;
   assign prdata  = prdata_r;

   always_comb begin
      case (paddr)
         `HSW_ADDR_CTRL:   rd_nxt = 32'(ctrl_r);
         `HSW_ADDR_START:  rd_nxt = 32'(start_r);
         `HSW_ADDR_STATUS: rd_nxt = 32'({s.pg, win_hit, dis_r, pg_rel_r,
                                         lim_r, gate_r, state_r});
         `HSW_ADDR_EVENT:  rd_nxt = 32'(ev_r);
         default:          rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable) begin
         prdata_r <= rd_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r  <= `HSW_CTRL_RST;
         start_r <= 16'(`HSW_T_START_US);
      end else if (wr && paddr == `HSW_ADDR_CTRL) begin
         ctrl_r <= pwdata[1:0];
      end else if (wr && paddr == `HSW_ADDR_START) begin
         start_r <= pwdata[15:0];
      end
   end

   // sticky events, set wins over write-one-to-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_r <= `HSW_EV_RST;
      end else begin
         ev_r <= (ev_r & ~({4{wr && paddr == `HSW_ADDR_EVENT}} &
                  pwdata[3:0])) | {win_hit, oc};
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_start_entry_cond: assert property (
      (state_r == ST_START) && ($past(state_r) != ST_START) |->
         $past(uv_done) && $past(all_on) && ($past(state_r) != ST_FAULT))
      else $error("startup entered without its conditions");

   a_startup_no_fault: assert property (
      (state_r == ST_START) |=> (state_r != ST_FAULT) && (state_r != ST_RETRY))
      else $error("fault raised during startup");

   a_power_good_n_after_delay: assert property (
      $rose(state_r == ST_RUN) |->
         ($past(state_r) == ST_PGDLY) && ($past(tmr_r) == POWER_GOOD_N_US - 1))
      else $error("run entered before power-good delay");

   a_fast_fault_time: assert property (
      norm && (|s.fast) && !both_low |=>
         (state_r == ST_FAULT || state_r == ST_RETRY) ##1
         (gate_r == 2'h0) && dis_r)
      else $error("fast trip did not fault in time");

   a_fault_outputs_off: assert property (
      (state_r == ST_FAULT) || (state_r == ST_RETRY) |=>
         (gate_r == 2'h0) && (pg_rel_r == 2'h0) && dis_r)
      else $error("gates or power-good active in fault");

   a_monitor_power_good_n: assert property (
      ctrl_r[`HSW_CTRL_MONITOR] && (state_r == ST_RUN) && win_hit[0] &&
      !(|oc) && !both_low |=> (state_r == ST_RUN) && !pg_rel_r[0])
      else $error("monitor window fault handled wrongly");

   a_latch_holds: assert property (
      (state_r == ST_FAULT) && !on_cyc && !sup_cyc && !both_low |=>
         (state_r == ST_FAULT))
      else $error("latched fault left without a clear");

   a_retry_holds: assert property (
      (state_r == ST_RETRY) && !sup_cyc && !both_low &&
      !(tdone && per_r == 6'(`HSW_RETRY_PERIODS - 1)) |=>
         (state_r == ST_RETRY))
      else $error("retry wait cut short");

   a_lock_restart: assert property (
      both_low |=> (state_r == ST_LOCK) && (uv_cnt_r == 16'h0000))
      else $error("lockout not restarted");

   a_gate_needs_on: assert property (
      gate_r[1] |-> $past(s.on[1]))
      else $error("gate on without enable");
endmodule // hsw_seq
`default_nettype wire

/* hsw_board_model.sv */
// backplane supplies, load and pull-ups around the sequencer
`timescale 1ns/1ps
`default_nettype none
module hsw_board_model import hsw_pkg::*; #(
   parameter int INRUSH_CYC = 300
) (
   // clock
   input  wire logic       pclk,
   // bench requests
   input  wire hsw_pins_t  cmd,
   // block outputs
   input  wire logic [1:0] gate_drive,
   input  wire logic [1:0] pg_out,
   input  wire logic [1:0] pg_oe,
   // pin levels seen by the block
   output var  hsw_pins_t  pins
);
   int   inrush_cnt = 0;
   logic gate_q     = 1'b0;

   // load capacitance draws inrush after each channel 1 turn-on
   always_ff @(posedge pclk) begin
      gate_q <= gate_drive[0];
      if (gate_drive[0] && !gate_q) begin
         inrush_cnt <= INRUSH_CYC;
      end else if (inrush_cnt > 0) begin
         inrush_cnt <= inrush_cnt - 1;
      end
   end

   // open-drain pins float up when released
   always_comb begin
      pins         = cmd;
      pins.fast[0] = cmd.fast[0] | (gate_drive[0] && inrush_cnt > 0);
      pins.pg[0]   = pg_oe[0] ? pg_out[0] : 1'b1;
      pins.pg[1]   = pg_oe[1] ? pg_out[1] : 1'b1;
   end
endmodule // hsw_board_model
`default_nettype wire

/* tb_dual_hotswap_fault_sequencer.sv */
// self-checking bench of the hot-swap sequencer
`timescale 1ns/1ps
`default_nettype none
`include "hsw_defines.svh"
module tb_dual_hotswap_fault_sequencer import hsw_pkg::*;;
   typedef struct packed {
      logic [31:0] data;
      logic [31:0] mask;
      logic        err;
   } hsw_note_t;
   localparam logic [31:0] MS = 32'h0000_0007;
   localparam logic [31:0] MG = 32'h0000_0018;
   localparam logic [31:0] MP = 32'h0000_3180;
   localparam logic [31:0] ML = 32'h0000_0020;
   localparam logic [31:0] MD = 32'h0000_0200;
   localparam logic [31:0] MO = 32'h0000_33f8;
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [1:0]  gate;
   logic [1:0]  lim;
   logic        disch;
   logic [1:0]  pg_out;
   logic [1:0]  pg_oe;
   hsw_pins_t   cmd     = '0;
   hsw_pins_t   pins;
   hsw_note_t   notes[$];
   hsw_note_t   cur;
   int          mismatches = 0;
   int          cmp_count  = 0;
   int          glitch;
   logic [31:0] pin_w;

   always #2.5 pclk = ~pclk;

   hsw_seq #(.UVLO_US(16'h0005), .START_US(16'h0003), .POWER_GOOD_N_US(16'h0002),
      .CLEAR_US(16'h0002), .SLOW_MAX_US(16'h0004))
   DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .supply_in_ch1(pins.sup[0]),
      .supply_in_ch2(pins.sup[1]), .chan1_enable_in(pins.on[0]),
      .chan2_enable_in(pins.on[1]), .startup_time_set(pins.tim_float),
      .slow_trip_ch1(pins.slow[0]), .slow_trip_ch2(pins.slow[1]),
      .slow_big_ch1(pins.big[0]), .slow_big_ch2(pins.big[1]),
      .fast_trip_ch1(pins.fast[0]), .fast_trip_ch2(pins.fast[1]),
      .output_window_ch1(pins.win[0]), .output_window_ch2(pins.win[1]),
      .gate_drive_ch1(gate[0]), .gate_drive_ch2(gate[1]),
      .gate_limit_ch1(lim[0]), .gate_limit_ch2(lim[1]),
      .gate_discharge(disch), .power_good_ch1_in(pins.pg[0]),
      .power_good_ch2_in(pins.pg[1]), .power_good_ch1_out(pg_out[0]),
      .power_good_ch1_oe(pg_oe[0]), .power_good_ch2_out(pg_out[1]),
      .power_good_ch2_oe(pg_oe[1]));

   hsw_board_model board (.pclk(pclk), .cmd(cmd), .gate_drive(gate),
      .pg_out(pg_out), .pg_oe(pg_oe), .pins(pins));

   task automatic finish_test;
      if (notes.size() != 0) begin
         mismatches++;
      end
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // result watcher: each completed transfer retires the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         if (notes.size() == 0) begin
            $display("Error apb_note expected a note seen none");
            mismatches++;
         end else begin
            cur = notes.pop_front();
            cmp_count++;
            if ((prdata & cur.mask) !== (cur.data & cur.mask) ||
                pslverr !== cur.err) begin
               $display("Error apb_%h expected %h/%b seen %h/%b", paddr,
                  cur.data & cur.mask, cur.err, prdata & cur.mask, pslverr);
               mismatches++;
            end
            // output pins must agree with the noted status word
            if (!pwrite && paddr == `HSW_ADDR_STATUS) begin
               pin_w = {18'h0_0000, pins.pg, 2'h0, disch, ~pg_oe, lim, gate,
                        3'h0};
               cmp_count++;
               if ((pin_w & cur.mask & MO) !== (cur.data & cur.mask & MO) ||
                   pg_out !== 2'h0) begin
                  $display("Error pins expected %h seen %h",
                     cur.data & cur.mask & MO, pin_w & cur.mask & MO);
                  mismatches++;
               end
            end
         end
      end
   end

   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d, input logic [31:0] e, input logic [31:0] m,
      input logic err);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      notes.push_back('{e, m, err});
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         $display("Error pready expected 1 seen %b", pready);
         mismatches++;
         finish_test();
      end
   endtask

   task automatic st(input logic [31:0] e, input logic [31:0] m);
      apb(1'b0, `HSW_ADDR_STATUS, 32'h0000_0000, e, m, 1'b0);
   endtask

   task automatic us(input int n);
      repeat (n * 200) @(posedge pclk);
   endtask

   function automatic logic [31:0] sv(input logic [2:0] s,
      input logic [1:0] g, input logic [1:0] p);
      return {18'h0_0000, p, 3'h0, p, 2'h0, g, s};
   endfunction

   initial begin
      repeat (99000) @(posedge pclk);
      $display("Error watchdog expected end seen timeout");
      mismatches++;
      finish_test();
   end

   initial begin
      void'($urandom(32'h6061_cc98));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `HSW_ADDR_CTRL, 0, 0, 32'h0000_0003, 0);
      apb(0, `HSW_ADDR_START, 0, 32'h0000_2328, 32'h0000_ffff, 0);
      apb(0, `HSW_ADDR_EVENT, 0, 0, 32'h0000_000f, 0);
      apb(1, 12'h010, $urandom, 0, 0, 1);
      apb(0, 12'h010, 0, 0, 32'hffff_ffff, 1);
      apb(1, `HSW_ADDR_START, 32'h0000_0003, 0, 0, 0);
      apb(0, `HSW_ADDR_START, 0, 32'h0000_0003, 32'h0000_ffff, 0);
      apb(1, `HSW_ADDR_STATUS, $urandom, 0, 0, 0);
      // power-up, slow overdrive and inrush during startup
      cmd.sup <= 2'b11;
      us(3);
      st(sv(ST_LOCK, 2'b00, 2'b00), MS | MG | MP);
      us(4);
      st(sv(ST_WAIT, 2'b00, 2'b00), MS | MG);
      cmd.on  <= 2'b11;
      cmd.big <= 2'b11;
      us(1);
      st(sv(ST_START, 2'b11, 2'b00) | ML, MS | MG | MP | ML);
      us(1);
      cmd.big <= 2'b00;
      us(2);
      st(sv(ST_PGDLY, 2'b11, 2'b00), MS | MG | MP);
      us(2);
      st(sv(ST_RUN, 2'b11, 2'b11), MS | MG | MP);
      // latched fast overcurrent
      cmd.fast[1] <= 1'b1;
      us(1);
      st(sv(ST_FAULT, 2'b00, 2'b00) | MD, MS | MG | MP | MD);
      cmd.fast[1] <= 1'b0;
      apb(0, `HSW_ADDR_EVENT, 0, 32'h0000_0002, 32'h0000_0003, 0);
      apb(1, `HSW_ADDR_EVENT, 32'h0000_0002, 0, 0, 0);
      apb(0, `HSW_ADDR_EVENT, 0, 0, 32'h0000_000f, 0);
      cmd.on <= 2'b10;
      us(1);
      cmd.on <= 2'b11;
      us(2);
      st(sv(ST_FAULT, 2'b00, 2'b00), MS | MG);
      cmd.on <= 2'b10;
      us(3);
      cmd.on <= 2'b11;
      us(1);
      st(sv(ST_START, 2'b11, 2'b00), MS | MG);
      us(6);
      // monitoring variant window faults
      apb(1, `HSW_ADDR_CTRL, 32'h0000_0002, 0, 0, 0);
      glitch = 5 + ($urandom % 15);
      cmd.win <= 2'b01;
      us(glitch);
      cmd.win <= 2'b00;
      us(2);
      st(sv(ST_RUN, 2'b11, 2'b11), MS | MG | MP);
      cmd.win <= 2'b01;
      us(23);
      st(sv(ST_RUN, 2'b11, 2'b10), MS | MG | MP);
      cmd.win <= 2'b00;
      us(22);
      st(sv(ST_RUN, 2'b11, 2'b11), MS | MG | MP);
      // protection variant with autoretry
      apb(1, `HSW_ADDR_CTRL, 32'h0000_0001, 0, 0, 0);
      cmd.win <= 2'b10;
      us(23);
      st(sv(ST_RETRY, 2'b00, 2'b00), MS | MG | MP);
      cmd.win <= 2'b00;
      cmd.on  <= 2'b01;
      us(3);
      cmd.on <= 2'b11;
      us(1);
      st(sv(ST_RETRY, 2'b00, 2'b00), MS | MG);
      cmd.sup <= 2'b10;
      us(3);
      cmd.sup <= 2'b11;
      us(2);
      st(sv(ST_START, 2'b11, 2'b00), MS | MG);
      us(6);
      // slow overcurrent, then the full retry delay
      cmd.slow <= 2'b01;
      us(2);
      st(sv(ST_RUN, 2'b11, 2'b11), MS | MG);
      us(4);
      st(sv(ST_RETRY, 2'b00, 2'b00), MS | MG | MP);
      cmd.slow <= 2'b00;
      us(178);
      st(sv(ST_RETRY, 2'b00, 2'b00), MG | MP);
      us(14);
      st(sv(ST_START, 2'b11, 2'b00), MG | MP);
      us(6);
      // channel enable and double supply loss
      cmd.on <= 2'b01;
      us(1);
      st(sv(ST_RUN, 2'b01, 2'b01), MS | MG | MP);
      cmd.sup <= 2'b00;
      us(1);
      st(sv(ST_LOCK, 2'b00, 2'b00), MS | MG);
      cmd.sup       <= 2'b01;
      cmd.on        <= 2'b11;
      cmd.tim_float <= 1'b1;
      us(3);
      st(sv(ST_LOCK, 2'b00, 2'b00), MS);
      us(3);
      st(sv(ST_START, 2'b11, 2'b00), MS | MG);
      repeat (2) @(posedge pclk);
      finish_test();
   end
endmodule // tb_dual_hotswap_fault_sequencer
`default_nettype wire
